// ==== ppc_pad_model.sv ====
// ppc_pad_model: pads and outside drivers of one port
// assumes pull-up enables come from the port block
`timescale 1ns/1ps
`default_nettype none
module ppc_pad_model (
  input  wire logic       clk,
  input  wire logic [7:0] pu,   // weak pull-up per pin
  input  wire logic [7:0] oe,   // outside driver active
  input  wire logic [7:0] val,  // outside level
  output logic      [7:0] pin   // resolved pad level
);
  logic [7:0] wander = 8'h55; // released pin without pull-up drifts
  always @(posedge clk) wander <= ~wander;
  assign pin = (oe & val) | (~oe & pu) | (~oe & ~pu & wander);
endmodule // ppc_pad_model
`default_nettype wire

// ==== ppc_pkg.sv ====
// ppc_pkg: constants shared by the port pin configuration block
// assumes an 8-bit register file reached through address/control registers
package ppc_pkg;
  // sub-register indices loaded into the port address register
  localparam logic [7:0] SUB_PULLUP   = 8'h06;  // weak pull-up enables
  localparam logic [7:0] SUB_AF_FIRST = 8'h07;  // first alt-function select
  localparam logic [7:0] SUB_AF_SECOND = 8'h08; // second alt-function select
  // direct read-only sample register addresses
  localparam logic [11:0] ADDR_PA_SAMPLE = 12'hfd2;
  localparam logic [11:0] ADDR_PB_SAMPLE = 12'hfd6;
  localparam logic [11:0] ADDR_PC_SAMPLE = 12'hfda;
  // reset values
  localparam logic [7:0] RST_PULLUP_ABC   = 8'h00;
  localparam logic [7:0] RST_PULLUP_D     = 8'h01;
  localparam logic [7:0] RST_SMALL_PORT_A = 8'h04;
  localparam logic [7:0] RST_AF_SECOND    = 8'h00;
  localparam logic [7:0] RST_AF_FIRST     = 8'h00;
  localparam logic [7:0] RST_ADDR_INDEX   = 8'h00;
  localparam logic [7:0] RST_STOP_SRC     = 8'h00;
  // port identifiers
  typedef enum logic [1:0] {PPC_PORT_A, PPC_PORT_B, PPC_PORT_C, PPC_PORT_D} ppc_port_t;
endpackage

// ==== ppc_port.sv ====
// ppc_port: per-port pin configuration sub-registers, sample register (ports A to C only),
// alternate-function steering and stop-recovery detection
// assumes an 8-bit register file strobe interface on SYS_CLK and a core stop flag
// assumes AF_ENABLE, STOP_SRC and IN_STOP come from logic on SYS_CLK
// pads are asynchronous and pass the two-flop synchroniser first
// every output is a flop, so pin-facing values lag the registers by one cycle
`timescale 1ns/1ps
`default_nettype none
module ppc_port #(
  parameter ppc_pkg::ppc_port_t PORT     = ppc_pkg::PPC_PORT_A,
  parameter bit                 SMALL_PKG = 1'b0,   // smallest package variant
  parameter logic [7:0]         BONDED    = 8'hff,  // pins bonded out
  parameter logic [11:0]        ADDR_REG  = 12'hfd0, // port address register
  parameter logic [11:0]        CTRL_REG  = 12'hfd1  // port control register
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic [11:0] REG_ADDR,      // register file address
  input  wire logic        REG_WR,        // write strobe
  input  wire logic        REG_RD,        // read strobe
  input  wire logic [7:0]  REG_WDATA,     // write data
  output logic      [7:0]  REG_RDATA,     // registered read data
  output logic             REG_RHIT,      // read hit this block
  input  wire logic [7:0]  PIN_IN,        // raw pad levels
  input  wire logic [7:0]  AF_ENABLE,     // per-pin alternate-function enable
  input  wire logic [7:0]  STOP_SRC,      // per-pin stop-recovery source bits
  input  wire logic        IN_STOP,       // core is in stop mode
  output logic      [7:0]  PULLUP_EN,     // weak pull-up drive per pin
  output logic      [7:0]  AF_SEL_LO,     // gated first select bit per pin
  output logic      [7:0]  AF_SEL_HI,     // gated second select bit per pin
  output logic      [7:0]  AF_ACTIVE,     // pin under alternate function
  output logic             STOP_RECOVER   // one-cycle recovery request
);
  // reset values depend on port and package
  localparam logic [7:0] PU_RST = (SMALL_PKG && PORT == ppc_pkg::PPC_PORT_A) ?
                                  ppc_pkg::RST_SMALL_PORT_A :
                                  (PORT == ppc_pkg::PPC_PORT_D) ?
                                  ppc_pkg::RST_PULLUP_D : ppc_pkg::RST_PULLUP_ABC;
  localparam logic [7:0] AF2_RST = (SMALL_PKG && PORT == ppc_pkg::PPC_PORT_A) ?
                                   ppc_pkg::RST_SMALL_PORT_A :
                                   ppc_pkg::RST_AF_SECOND;
  localparam logic [11:0] SAMPLE_ADDR = (PORT == ppc_pkg::PPC_PORT_A) ? ppc_pkg::ADDR_PA_SAMPLE :
                                        (PORT == ppc_pkg::PPC_PORT_B) ? ppc_pkg::ADDR_PB_SAMPLE :
                                        ppc_pkg::ADDR_PC_SAMPLE;
  localparam bit HAS_SAMPLE = (PORT != ppc_pkg::PPC_PORT_D);

  // strobe qualified by an address match
  function automatic logic strobe_hit(
    input logic        strobe,  // read or write strobe
    input logic [11:0] addr,    // address on the bus
    input logic [11:0] target   // register being decoded
  );
    return strobe && (addr == target);
  endfunction

  // one-hot pick of the three sub-registers from the index
  function automatic logic [2:0] sub_select(
    input logic [7:0] index     // current index register
  );
    logic [2:0] sel;            // pull-up, first set, second set
    sel = 3'b000;
    case (index)
      ppc_pkg::SUB_PULLUP:    sel = 3'b001;
      ppc_pkg::SUB_AF_FIRST:  sel = 3'b010;
      ppc_pkg::SUB_AF_SECOND: sel = 3'b100;
      default:                sel = 3'b000; // other sub-registers elsewhere
    endcase
    return sel;
  endfunction

  logic [7:0] pin_sync;                    // synchronised pad levels
  logic [7:0] index_reg,  index_next;      // sub-register index
  logic [7:0] pullup_reg, pullup_next;     // weak pull-up enables
  logic [7:0] af1_reg,    af1_next;        // first select set
  logic [7:0] af2_reg,    af2_next;        // second select set
  logic [7:0] rdata_next;                  // read mux
  logic       rhit_next;                   // read decode hit
  logic [7:0] prev_reg;                    // previous sampled levels
  logic       recover_next;                // transition detect
  logic [2:0] sub_sel;                     // decoded sub-register pick
  logic [7:0] pu_out_next;                 // pull-up drive next
  logic [7:0] sel_lo_next;                 // gated first select next
  logic [7:0] sel_hi_next;                 // gated second select next
  logic [7:0] active_next;                 // alternate enable next

  // index decode shared by the write and read paths
  assign sub_sel = sub_select(index_reg);

  // pads pass two flops before use
  ppc_sync #(.W(8)) u_sync (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .d     (PIN_IN),
    .q     (pin_sync)
  );

  // register write decode
  always_comb
  begin
    index_next  = index_reg;  // held until rewritten
    pullup_next = pullup_reg;
    af1_next    = af1_reg;
    af2_next    = af2_reg;
    if (strobe_hit(REG_WR, REG_ADDR, ADDR_REG))
    begin
      index_next = REG_WDATA; // new sub-register index
    end
    else if (strobe_hit(REG_WR, REG_ADDR, CTRL_REG))
    begin
      // only the sub-register picked by the index takes the data
      if (sub_sel[0])
      begin
        pullup_next = REG_WDATA;
      end
      if (sub_sel[1])
      begin
        af1_next = REG_WDATA;
      end
      if (sub_sel[2])
      begin
        af2_next = REG_WDATA;
      end
    end
  end

  // pin-facing outputs; unbonded pins never get a pull-up
  always_comb
  begin
    pu_out_next = pullup_reg & BONDED;
    sel_lo_next = af1_reg & AF_ENABLE;
    sel_hi_next = af2_reg & AF_ENABLE;
    active_next = AF_ENABLE;
  end

  // read mux; sample register ignores writes
  always_comb
  begin
    rdata_next = 8'h00;
    rhit_next  = 1'b0;
    if (REG_RD)
    begin
      if (REG_ADDR == ADDR_REG)
      begin
        rdata_next = index_reg;
        rhit_next  = 1'b1;
      end
      else if (REG_ADDR == CTRL_REG)
      begin
        rhit_next = 1'b1;
        case (sub_sel)
          3'b001:  rdata_next = pullup_reg;
          3'b010:  rdata_next = af1_reg;
          3'b100:  rdata_next = af2_reg;
          default: rdata_next = 8'h00;      // unknown index reads zero
        endcase
      end
      else if (HAS_SAMPLE && REG_ADDR == SAMPLE_ADDR)
      begin
        rdata_next = pin_sync & BONDED;
        rhit_next  = 1'b1;
      end
    end
  end

  // any change on a bonded recovery-source pin while stopped
  always_comb
  begin
    recover_next = IN_STOP && |((pin_sync ^ prev_reg) & STOP_SRC & BONDED);
  end

  // state and output registers
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      index_reg    <= ppc_pkg::RST_ADDR_INDEX;
      pullup_reg   <= PU_RST;
      af1_reg      <= ppc_pkg::RST_AF_FIRST;
      af2_reg      <= AF2_RST;
      prev_reg     <= 8'h00;
      REG_RDATA    <= 8'h00;
      REG_RHIT     <= 1'b0;
      PULLUP_EN    <= 8'h00;
      AF_SEL_LO    <= 8'h00;
      AF_SEL_HI    <= 8'h00;
      AF_ACTIVE    <= 8'h00;
      STOP_RECOVER <= 1'b0;
    end
    else
    begin
      index_reg    <= index_next;
      pullup_reg   <= pullup_next;
      af1_reg      <= af1_next;
      af2_reg      <= af2_next;
      prev_reg     <= pin_sync;
      REG_RDATA    <= rdata_next;
      REG_RHIT     <= rhit_next;
      PULLUP_EN    <= pu_out_next;
      AF_SEL_LO    <= sel_lo_next;
      AF_SEL_HI    <= sel_hi_next;
      AF_ACTIVE    <= active_next;
      STOP_RECOVER <= recover_next;
    end
  end
endmodule // ppc_port
`default_nettype wire

// ==== ppc_port_sva.sv ====
// ppc_port_sva: port checks for ppc_port
// assumes a bind onto each ppc_port instance
`timescale 1ns/1ps
`default_nettype none
module ppc_port_sva #(parameter logic [7:0] BONDED = 8'hff) (
  input wire logic        SYS_CLK,
  input wire logic        RESETN,
  input wire logic [11:0] REG_ADDR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        REG_RHIT,
  input wire logic [7:0]  AF_ENABLE,
  input wire logic [7:0]  STOP_SRC,
  input wire logic        IN_STOP,
  input wire logic [7:0]  PULLUP_EN,
  input wire logic [7:0]  AF_SEL_LO,
  input wire logic [7:0]  AF_SEL_HI,
  input wire logic [7:0]  AF_ACTIVE,
  input wire logic        STOP_RECOVER
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  logic hit; // read decoded by port a
  assign hit = REG_ADDR == 12'hfd0 || REG_ADDR == 12'hfd1 || REG_ADDR == 12'hfd2;
  rd_hit_a: assert property (REG_RD && hit |=> REG_RHIT) else $error("no read hit");
  idle_zero_a: assert property (!REG_RD |=> !REG_RHIT && REG_RDATA == 8'h00)
    else $error("idle read data");
  miss_zero_a: assert property (REG_RD && !hit |=> !REG_RHIT && REG_RDATA == 8'h00)
    else $error("miss read data");
  bond_rd_a: assert property (REG_RD && REG_ADDR == 12'hfd2 |=> !(REG_RDATA & ~BONDED))
    else $error("unbonded bit read");
  pu_bond_a: assert property (!(PULLUP_EN & ~BONDED)) else $error("unbonded pull-up");
  af_gate_a: assert property (!((AF_SEL_LO | AF_SEL_HI) & ~AF_ACTIVE))
    else $error("select without enable");
  af_off_a: assert property (AF_ENABLE == 8'h00 |=> !(AF_SEL_LO | AF_SEL_HI))
    else $error("select not gated");
  stop_idle_a: assert property (!IN_STOP [*4] |-> !STOP_RECOVER) else $error("run wake");
  src_mask_a: assert property (STOP_SRC == 8'h00 [*4] |-> !STOP_RECOVER)
    else $error("masked wake");
  c_rd: cover property (REG_RD && hit ##1 REG_RHIT);
  c_wake: cover property (STOP_RECOVER);
  c_af: cover property (AF_SEL_LO != 8'h00);
endmodule // ppc_port_sva
bind ppc_port ppc_port_sva #(.BONDED(BONDED)) u_sva (.*);
`default_nettype wire

// ==== ppc_port_tb_top.sv ====
// ppc_port_tb_top: self-checking bench for ppc_port
// assumes the pad model and bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module ppc_port_tb_top;
  localparam logic [7:0] BND = 8'h3f; // two top pins unbonded
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, stp = 0, rec, rhit;
  logic [7:0] act;
  logic [11:0] addr = 0;
  logic [7:0] wd = 0, af_en = 0, src = 0, oe = 8'hff, val = 0, pu, pin, rdat, slo, shi;
  logic [7:0] m[3] = '{8'h00, 8'h00, 8'h00}; // model of the three sub-registers
  int n_mismatch = 0, n_checks = 0, idx, k;
  initial forever #2.5 clk = ~clk;
  ppc_port #(.BONDED(BND)) uut (.SYS_CLK(clk), .RESETN(rst_n), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wd), .REG_RDATA(rdat), .REG_RHIT(rhit), .PIN_IN(pin),
    .AF_ENABLE(af_en), .STOP_SRC(src), .IN_STOP(stp), .PULLUP_EN(pu), .AF_SEL_LO(slo),
    .AF_SEL_HI(shi), .AF_ACTIVE(act), .STOP_RECOVER(rec));
  ppc_pad_model pads (.clk(clk), .pu(pu), .oe(oe), .val(val), .pin(pin));
  // one strobed access, released a cycle later
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk); #1; wr = w; rd = !w; addr = a; wd = d;
    @(posedge clk); #1; wr = 0; rd = 0;
  endtask
  task automatic rchk(input string n, input logic [11:0] a, input logic [7:0] e);
    acc(0, a, 8'h00);
    `CHK(n, e, rdat)
    `CHK("hit", (a != 12'hfd6), rhit)
  endtask
  function automatic logic [7:0] ectl();
    return (idx > 5 && idx < 9) ? m[idx - 6] : 8'h00;
  endfunction
  task automatic wake(input logic [7:0] v, input int e);
    val = v; k = 0;
    repeat (8) begin @(posedge clk); #1; k += (rec === 1'b1); end
    `CHK("wake count", e, k)
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin #100000; n_mismatch++; final_report(); end
  initial begin
    k = $urandom(32'h785ec917);
    repeat (20) @(posedge clk);
    #1 rst_n = 1;
    for (idx = 6; idx < 9; idx++) begin
      acc(1, 12'hfd0, 8'(idx));
      rchk("rst", 12'hfd1, 8'h00);
    end
    `CHK("pullup rst", 8'h00, pu)
    $display("test reset done");
    // random index and data, invalid index included
    for (int i = 0; i < 16; i++) begin
      idx = 5 + $urandom % 4; k = $urandom; af_en = $urandom;
      acc(1, 12'hfd0, 8'(idx));
      acc(1, 12'hfd1, 8'(k));
      if (idx > 5) m[idx - 6] = 8'(k);
      rchk("ctrl", 12'hfd1, ectl());
      rchk("index", 12'hfd0, 8'(idx));
      rchk("ctrl again", 12'hfd1, ectl());
      `CHK("pullup", m[0] & BND, pu)
      `CHK("sel lo", m[1] & af_en, slo)
      `CHK("sel hi", m[2] & af_en, shi)
      `CHK("active", af_en, act)
    end
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      val = $urandom; repeat (3) @(posedge clk);
      rchk("sample", 12'hfd2, val & BND);
      acc(1, 12'hfd2, ~val);
      rchk("sample ro", 12'hfd2, val & BND);
    end
    rchk("unmapped", 12'hfd6, 8'h00);
    $display("test sample done");
    wake(8'h00, 0);
    src = 8'h01; stp = 1;
    wake(8'h00, 0);
    wake(8'h02, 0);
    wake(8'h03, 1);
    $display("test stop done");
    final_report();
  end
endmodule // ppc_port_tb_top
`default_nettype wire

// ==== ppc_sync.sv ====
// ppc_sync: two-flop synchroniser for a bus of pin levels
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module ppc_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg; // first stage, read only by q
  // two flops in series
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // ppc_sync
`default_nettype wire
